// ===== logic/pps_pkg.sv
// panel power sequencer package: state encoding, stage outputs, timing constants
// assumes one 125 MHz core clock and a synchronous active-high reset
// Operation
// - standby input falling low starts the panel power-down sequence
// - power-down control bit 3 set to one starts power-down
// - standby input rising high with bit 3 clear starts the panel power-up sequence
// - power-down control bit 3 cleared to zero with standby high starts power-up
// - four enables for logic supply, panel signals, bias and backlight switch as stages
// - wait between stages comes from the programmable delay register
// - bias enable never asserted while panel control and data are off
package pps_pkg;
   // clock rate and delay unit
   localparam int CLK_MHZ = 125;
   localparam int DELAY_UNIT_US = 1;
   localparam int UNIT_CYCLES = CLK_MHZ * DELAY_UNIT_US;
   localparam int DELAY_W = 8;
   localparam logic [DELAY_W-1:0] DELAY_RST = 8'h01;
   localparam int PD_BIT = 3;
   localparam int CTRL_W = 8;
   localparam logic [CTRL_W-1:0] CTRL_RST = 8'h00;

   // stage number 0 = all off .. 4 = all on
   typedef enum logic [2:0] {
      ST_OFF = 3'h0,
      ST_LOGIC = 3'h1,
      ST_SIG = 3'h2,
      ST_BIAS = 3'h3,
      ST_ON = 3'h4
   } pps_stage_t;

   // enables presented to the panel switches
   typedef struct packed {
      logic logic_supply_enable;
      logic panel_signal_enable;
      logic bias_supply_enable;
      logic backlight_enable;
   } pps_enables_t;
endpackage : pps_pkg

// ===== logic/pps_sequencer.sv
// panel power sequencer: steps panel supplies up or down one stage per delay
// assumes inputs synchronous to ref_clk_in; delay and control values held by the register owner
`timescale 1ns/1ps
module pps_sequencer import pps_pkg::*; #(
   parameter int UNIT_CYC = UNIT_CYCLES
) (
   // clock and reset
   input wire logic ref_clk_in,
   input wire logic rst_in,
   // requests
   input wire logic standby_request_n_in,
   input wire logic [CTRL_W-1:0] power_down_ctrl1_reg_in,
   input wire logic [DELAY_W-1:0] panel_seq_delay_reg_in,
   // panel switches
   output pps_enables_t enables_out,
   output logic busy_out
);
   pps_stage_t stage_ff, nxt_stage;
   logic [15:0] unit_ff, nxt_unit;
   logic [DELAY_W-1:0] left_ff, nxt_left;
   logic want_on;
   logic at_target;
   logic tick;
   pps_enables_t enables_ff, nxt_enables;
   // last count of one delay unit; a zero unit setting still waits one cycle
   localparam logic [15:0] UNIT_LAST = 16'((UNIT_CYC > 0 ? UNIT_CYC : 1) - 1);

   // level request: off if standby low or power-down bit set
   assign want_on = standby_request_n_in & ~power_down_ctrl1_reg_in[PD_BIT];
   assign at_target = want_on ? (stage_ff == ST_ON) : (stage_ff == ST_OFF);
   assign tick = (unit_ff == 16'h0000) && (left_ff == '0);
   assign busy_out = ~at_target;

   // interval counter; a reversed request lets the running wait finish, then steps from the current stage
   always_comb begin
      nxt_unit = unit_ff;
      nxt_left = left_ff;
      nxt_stage = stage_ff;
      if (at_target) begin
         nxt_unit = 16'((UNIT_CYC > 0 ? UNIT_CYC : 1) - 1);
         nxt_left = panel_seq_delay_reg_in;
      end else if (tick) begin
         // one stage step in the requested direction
         case (stage_ff)
            ST_OFF: nxt_stage = want_on ? ST_LOGIC : ST_OFF;
            ST_LOGIC: nxt_stage = want_on ? ST_SIG : ST_OFF;
            ST_SIG: nxt_stage = want_on ? ST_BIAS : ST_LOGIC;
            ST_BIAS: nxt_stage = want_on ? ST_ON : ST_SIG;
            ST_ON: nxt_stage = want_on ? ST_ON : ST_BIAS;
            default: nxt_stage = ST_OFF;
         endcase
         nxt_unit = 16'((UNIT_CYC > 0 ? UNIT_CYC : 1) - 1);
         nxt_left = panel_seq_delay_reg_in;
      end else if (unit_ff != 16'h0000) begin
         nxt_unit = unit_ff - 16'h0001;
      end else begin
         nxt_unit = 16'((UNIT_CYC > 0 ? UNIT_CYC : 1) - 1);
         nxt_left = left_ff - 1'b1;
      end
   end

   // state registers; reset leaves the panel fully off
   always_ff @(posedge ref_clk_in) begin
      if (rst_in) begin
         stage_ff <= ST_OFF;
         unit_ff <= 16'h0000;
         left_ff <= DELAY_RST;
         enables_ff <= '0;
      end else begin
         stage_ff <= nxt_stage;
         unit_ff <= nxt_unit;
         left_ff <= nxt_left;
         enables_ff <= nxt_enables;
      end
   end

   // enables decoded from the next stage and registered
   // a combinational decode of the stage code could glitch bias on for a moment
   always_comb begin
      nxt_enables.logic_supply_enable = (nxt_stage >= ST_LOGIC) && (nxt_stage <= ST_ON);
      nxt_enables.panel_signal_enable = (nxt_stage >= ST_SIG) && (nxt_stage <= ST_ON);
      nxt_enables.bias_supply_enable = (nxt_stage >= ST_BIAS) && (nxt_stage <= ST_ON);
      nxt_enables.backlight_enable = (nxt_stage == ST_ON);
   end

   // switches see only flip-flop outputs
   assign enables_out = enables_ff;

   bias_guard_a: assert property (@(posedge ref_clk_in) disable iff (rst_in)
      enables_out.bias_supply_enable |-> enables_out.panel_signal_enable)
      else $error("bias on while panel signals off");
   order_up_a: assert property (@(posedge ref_clk_in) disable iff (rst_in)
      $rose(enables_out.panel_signal_enable) |-> $past(enables_out.logic_supply_enable))
      else $error("signals rose before logic supply");
   order_down_a: assert property (@(posedge ref_clk_in) disable iff (rst_in)
      $fell(enables_out.bias_supply_enable) |-> !enables_out.backlight_enable)
      else $error("bias fell with backlight on");
   single_step_a: assert property (@(posedge ref_clk_in) disable iff (rst_in)
      $changed(enables_out) |=> $stable(enables_out))
      else $error("two stages in consecutive cycles");
   // off request with a due step at the logic stage goes to all-off next
   off_done_a: assert property (@(posedge ref_clk_in) disable iff (rst_in)
      (!want_on && stage_ff == ST_LOGIC && tick) |=> stage_ff == ST_OFF)
      else $error("last down step missed");
   on_step_a: assert property (@(posedge ref_clk_in) disable iff (rst_in)
      (want_on && stage_ff == ST_OFF && tick) |=> enables_out.logic_supply_enable)
      else $error("up step missed");
   wait_hold_a: assert property (@(posedge ref_clk_in) disable iff (rst_in)
      !tick |=> $stable(stage_ff))
      else $error("stage moved during interval");
   pd_bit_a: assert property (@(posedge ref_clk_in) disable iff (rst_in)
      (power_down_ctrl1_reg_in[PD_BIT] && stage_ff == ST_ON && tick) |=> stage_ff == ST_BIAS)
      else $error("power-down bit ignored");

   // checks below watch enable edges and levels, stage steps and the interval counter;
   // they hold for any unit setting and any delay setting

   reset_off_a: assert property (@(posedge ref_clk_in)
      rst_in |=> (enables_out == '0))
      else $error("enable left on through reset");

   bias_rise_a: assert property (@(posedge ref_clk_in) disable iff (rst_in)
      $rose(enables_out.bias_supply_enable) |-> $past(enables_out.panel_signal_enable))
      else $error("bias rose before panel signals");

   light_rise_a: assert property (@(posedge ref_clk_in) disable iff (rst_in)
      $rose(enables_out.backlight_enable) |-> $past(enables_out.bias_supply_enable))
      else $error("backlight rose before bias");

   // signals drop only once bias is gone
   sig_fall_a: assert property (@(posedge ref_clk_in) disable iff (rst_in)
      $fell(enables_out.panel_signal_enable) |-> !$past(enables_out.bias_supply_enable))
      else $error("signals fell with bias on");

   logic_fall_a: assert property (@(posedge ref_clk_in) disable iff (rst_in)
      $fell(enables_out.logic_supply_enable) |-> !$past(enables_out.panel_signal_enable))
      else $error("logic supply fell with signals on");

   // a due step moves exactly one stage toward the request
   sequence up_due_s;
      want_on && tick && (stage_ff != ST_ON);
   endsequence
   sequence down_due_s;
      !want_on && tick && (stage_ff != ST_OFF);
   endsequence
   property one_up_p;
      @(posedge ref_clk_in) disable iff (rst_in)
      up_due_s |=> (3'(stage_ff) == 3'($past(stage_ff)) + 3'h1);
   endproperty
   property one_down_p;
      @(posedge ref_clk_in) disable iff (rst_in)
      down_due_s |=> (3'(stage_ff) + 3'h1 == 3'($past(stage_ff)));
   endproperty
   step_up_a: assert property (one_up_p)
      else $error("up step skipped a stage");
   step_down_a: assert property (one_down_p)
      else $error("down step skipped a stage");

   // every fresh interval starts from the delay setting
   reload_a: assert property (@(posedge ref_clk_in) disable iff (rst_in)
      (at_target || tick) |=> ((left_ff == $past(panel_seq_delay_reg_in)) && (unit_ff == UNIT_LAST)))
      else $error("interval not reloaded");

   // unit counter counts down while waiting
   count_down_a: assert property (@(posedge ref_clk_in) disable iff (rst_in)
      (!at_target && !tick && (unit_ff != 16'h0000)) |=> (unit_ff == $past(unit_ff) - 16'h0001))
      else $error("unit counter skipped");

   // delay counter takes one per finished unit
   left_down_a: assert property (@(posedge ref_clk_in) disable iff (rst_in)
      (!at_target && !tick && (unit_ff == 16'h0000)) |=> (left_ff == $past(left_ff) - 1'b1))
      else $error("delay counter skipped");

   // switches hold while the interval runs
   hold_enables_a: assert property (@(posedge ref_clk_in) disable iff (rst_in)
      !tick |=> $stable(enables_out))
      else $error("enables moved inside an interval");

   // cleared bit with standby high keeps stepping up
   ctrl_up_a: assert property (@(posedge ref_clk_in) disable iff (rst_in)
      (!power_down_ctrl1_reg_in[PD_BIT] && standby_request_n_in && (stage_ff == ST_BIAS) && tick)
      |=> (stage_ff == ST_ON))
      else $error("cleared bit did not power up");

   // standby high steps up through the middle
   standby_up_a: assert property (@(posedge ref_clk_in) disable iff (rst_in)
      (standby_request_n_in && !power_down_ctrl1_reg_in[PD_BIT] && (stage_ff == ST_SIG) && tick)
      |=> (stage_ff == ST_BIAS))
      else $error("standby high did not power up");

   // standby low steps down through the middle
   standby_down_a: assert property (@(posedge ref_clk_in) disable iff (rst_in)
      (!standby_request_n_in && (stage_ff == ST_SIG) && tick) |=> (stage_ff == ST_LOGIC))
      else $error("standby low did not power down");

   // set bit steps down even with standby high
   pd_low_a: assert property (@(posedge ref_clk_in) disable iff (rst_in)
      (power_down_ctrl1_reg_in[PD_BIT] && (stage_ff == ST_BIAS) && tick) |=> (stage_ff == ST_SIG))
      else $error("set bit did not power down");

   // no enable stands without the logic supply
   off_all_a: assert property (@(posedge ref_clk_in) disable iff (rst_in)
      !enables_out.logic_supply_enable |-> (enables_out == '0))
      else $error("enable on without logic supply");

   // backlight only with every other supply on
   on_all_a: assert property (@(posedge ref_clk_in) disable iff (rst_in)
      enables_out.backlight_enable |-> (enables_out == '1))
      else $error("backlight on with a supply off");

   // stage code stays within the five stages
   stage_legal_a: assert property (@(posedge ref_clk_in) disable iff (rst_in)
      (stage_ff <= ST_ON))
      else $error("stage code out of range");
endmodule : pps_sequencer

// ===== bench/pps_panel_model.sv
// panel switch model: follows the enables, flags an unsafe supply mix
// assumes enables are levels sampled on the core clock
`timescale 1ns/1ps
module pps_panel_model import pps_pkg::*; (
   // clock
   input wire logic ref_clk_in,
   // switches
   input pps_enables_t enables_in,
   output logic damage_out
);
   // sticky, since one unsafe cycle can already hurt the glass
   logic damage_ff = 1'b0;
   assign damage_out = damage_ff;
   always @(posedge ref_clk_in) begin
      if (enables_in.bias_supply_enable && !enables_in.panel_signal_enable) begin
         damage_ff <= 1'b1;
      end
   end
endmodule : pps_panel_model

// ===== bench/tb.sv
// sequencer bench: stage order and spacing for all four request paths
// assumes the sequencer is built with a two-cycle delay unit
`timescale 1ns/1ps
`define CHK(a, b) n_checks++; if ((a) !== (b)) begin n_mismatch++; $display("[FAIL] %0t %h %h", $time, a, b); end
module tb;
   import pps_pkg::*;
   logic ref_clk_in = 1'b0, rst_in = 1'b1, sb_n = 1'b0, busy, dmg;
   logic [7:0] ctrl = 8'h00, dly = 8'h00;
   pps_enables_t en;
   int n_mismatch = 0, n_checks = 0, cyc = 0;
   pps_sequencer #(.UNIT_CYC(2)) i_pps_sequencer (.ref_clk_in(ref_clk_in), .rst_in(rst_in),
      .standby_request_n_in(sb_n), .power_down_ctrl1_reg_in(ctrl), .panel_seq_delay_reg_in(dly),
      .enables_out(en), .busy_out(busy));
   pps_panel_model i_pps_panel_model (.ref_clk_in(ref_clk_in), .enables_in(en), .damage_out(dmg));
   initial forever #4 ref_clk_in = ~ref_clk_in;
   task end_of_test;
      $display("mismatches %0d checks %0d", n_mismatch, n_checks);
      if (n_mismatch == 0 && n_checks > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask : end_of_test
   // waits for the next stage change; gap 0 skips the spacing check
   task step(input logic [3:0] exp, input int gap);
      logic [3:0] prev;
      int k;
      prev = en;
      k = 0;
      while (en === prev && k < 60) begin
         @(posedge ref_clk_in);
         #1;
         k++;
      end
      `CHK(en, exp)
      if (gap > 0) begin
         `CHK(k, gap)
      end
      `CHK(dmg, 1'b0)
      `CHK(busy, ((exp != 4'hf) && (exp != 4'h0)))
   endtask : step
   task up_by_standby;
      @(posedge ref_clk_in);
      sb_n <= 1'b1;
      step(4'h8, 0);
      step(4'hc, 2);
      step(4'he, 2);
      step(4'hf, 2);
   endtask : up_by_standby
   task down_by_standby;
      @(posedge ref_clk_in);
      sb_n <= 1'b0;
      step(4'he, 0);
      step(4'hc, 2);
      step(4'h8, 2);
      step(4'h0, 2);
   endtask : down_by_standby
   task up_by_ctrl;
      @(posedge ref_clk_in);
      ctrl <= 8'h08;
      sb_n <= 1'b1;
      dly <= 8'h03;
      repeat (20) @(posedge ref_clk_in);
      `CHK(en, 4'h0)
      `CHK(busy, 1'b0)
      ctrl <= 8'h00;
      step(4'h8, 0);
      step(4'hc, 8);
      step(4'he, 8);
      step(4'hf, 8);
   endtask : up_by_ctrl
   task down_by_ctrl;
      @(posedge ref_clk_in);
      ctrl <= 8'h08;
      step(4'he, 0);
      step(4'hc, 8);
      step(4'h8, 8);
      step(4'h0, 8);
      repeat (4) @(posedge ref_clk_in);
      `CHK(busy, 1'b0)
   endtask : down_by_ctrl
   // cycle ceiling cuts a hang short
   always @(posedge ref_clk_in) begin
      cyc++;
      if (cyc == 3000) begin
         n_mismatch++;
         end_of_test();
      end
   end
   initial begin
      repeat (12) @(posedge ref_clk_in);
      rst_in <= 1'b0;
      up_by_standby();
      down_by_standby();
      up_by_ctrl();
      down_by_ctrl();
      end_of_test();
   end
endmodule : tb
